// file: common/vca_pkg.sv
// Constants, register map and state types of the video capture adjust block
package vca_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_DECIM    = 8'h00;
  localparam logic [7:0] OFF_CTRL     = 8'h04;
  localparam logic [7:0] OFF_HUE      = 8'h08;
  localparam logic [7:0] OFF_CONTRAST = 8'h0c;
  localparam logic [7:0] OFF_SATU     = 8'h10;
  localparam logic [7:0] OFF_SATV     = 8'h14;
  localparam logic [7:0] OFF_LUMA_OFFSET   = 8'h18;
  localparam logic [7:0] OFF_VBI      = 8'h1c;
  localparam logic [7:0] OFF_HDELAY   = 8'h20;
  localparam logic [7:0] OFF_VWIN     = 8'h24;
  localparam logic [7:0] OFF_STATUS   = 8'h28;
  // Field positions
  localparam int DEC_FIELD_BIT  = 7;
  localparam int DEC_PARITY_BIT = 6;
  localparam int CTRL_PAL_BIT   = 0;
  localparam int CTRL_AGC_BIT   = 1;
  localparam int CTRL_LCR_BIT   = 2;
  localparam int CTRL_LIM_BIT   = 3;
  localparam int CTRL_CORE_LSB  = 4;
  localparam int VBI_CNT_UP_BIT = 8;
  localparam int VBI_EVEN_BIT   = 9;
  localparam int VBI_ODD_BIT    = 10;
  localparam int VBI_EXT_BIT    = 11;
  localparam int VBI_CAPE_BIT   = 12;
  localparam int VBI_CAPO_BIT   = 13;
  localparam int VBI_RAWE_BIT   = 14;
  localparam int VBI_RAWO_BIT   = 15;
  localparam int VWIN_OFF_LSB   = 16;
  // Values after reset and automatic gain limits
  localparam logic [7:0]  CTRL_RST     = 8'h06;
  localparam logic [8:0]  GAIN_RST     = 9'h100;
  localparam logic [7:0]  AGC_UNITY    = 8'h40;
  localparam logic [7:0]  AGC_MIN      = 8'h20;
  localparam logic [7:0]  AGC_MAX      = 8'h80;
  localparam logic [9:0]  VOFF_RST     = 10'h016;
  localparam logic [9:0]  VWIN_RST     = 10'h1e0;
  // Sequence lengths, counts, limits and levels
  localparam logic [6:0]  SEQ_NTSC     = 7'd60;
  localparam logic [6:0]  SEQ_PAL      = 7'd50;
  localparam logic [6:0]  LOWCOL_LINES = 7'd127;
  localparam logic [15:0] LOW_PCT_NTSC = 16'd25;
  localparam logic [15:0] LOW_PCT_PAL  = 16'd35;
  localparam logic [15:0] HI_PCT_NTSC  = 16'd43;
  localparam logic [15:0] HI_PCT_PAL   = 16'd60;
  localparam logic [15:0] PCT_FULL     = 16'd100;
  localparam logic [9:0]  BLK_NTSC     = 10'd434;
  localparam logic [9:0]  BLK_PAL      = 10'd650;
  localparam logic [9:0]  BLK_NTSC_EXT = 10'd450;
  localparam logic [9:0]  BLK_PAL_EXT  = 10'd674;
  localparam logic [8:0]  EXT_LINES    = 9'd10;
  localparam logic [7:0]  LIMITED_BLACK = 8'd16;
  localparam logic [7:0]  CHROMA_ZERO  = 8'h80;

  typedef enum logic [1:0] {VCA_VBI_IDLE, VCA_VBI_DELAY, VCA_VBI_LINE, VCA_VBI_RAW} vca_vbi_e;

  typedef struct packed {
    logic [7:0]  decim;
    logic [7:0]  ctrl;
    logic [7:0]  hue;
    logic [8:0]  contrast;
    logic [8:0]  blue_diff_gain;
    logic [8:0]  red_diff_gain;
    logic [7:0]  luma_offset;
    logic [15:0] vbi_cfg;
    logic [9:0]  hdelay;
    logic [9:0]  vwin;
    logic [9:0]  voff;
    logic [15:0] vbi_cfg_a;
    logic [9:0]  hdelay_a;
    logic [9:0]  voff_a;
    logic [5:0]  dec_cnt;
    logic [6:0]  dec_acc;
    logic        dec_run;
    logic        active;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [7:0]  agc;
    logic [6:0]  low_cnt;
    logic [6:0]  hi_cnt;
    logic        kill;
    logic        line_q;
    logic        odd;
    logic [9:0]  line;
    vca_vbi_e    vbi;
    logic [10:0] samp;
    logic [8:0]  dw;
    logic [17:0] raw_dw;
    logic [1:0]  pk;
    logic [31:0] pack;
    logic        fifo_valid;
    logic [7:0]  y;
    logic [7:0]  cb;
    logic [7:0]  cr;
    logic        pv;
    logic [7:0]  hue_out;
  } vca_state_s;
endpackage

// file: hdl/vca_core.sv
// Video output stage: temporal decimation, picture adjustment, chroma control and VBI capture
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module vca_core
  import vca_pkg::*;
#(
  parameter logic [7:0] BURST_NOMINAL = 8'd128
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        line_start_strobe_i,
  input  wire logic        field_start_strobe_i,
  input  wire logic        field_odd_i,
  input  wire logic [7:0]  burst_amp_i,
  input  wire logic        pix_valid_i,
  input  wire logic [7:0]  y_i,
  input  wire logic [7:0]  cb_i,
  input  wire logic [7:0]  cr_i,
  input  wire logic        vbi_sample_valid_i,
  input  wire logic [7:0]  vbi_sample_i,
  output logic             active_o,
  output logic             pix_valid_o,
  output logic      [7:0]  y_o,
  output logic      [7:0]  cb_o,
  output logic      [7:0]  cr_o,
  output logic      [7:0]  hue_phase_o,
  output logic      [31:0] fifo_data_o,
  output logic             fifo_valid_o
);

  vca_state_s s;
  vca_state_s next_s;

  // Offset binary chroma times gain (unity 0x100), saturated back to offset binary
  function automatic logic [7:0] chroma_scale(input logic [7:0] c, input logic [10:0] g);
    logic signed [8:0]  u;
    logic signed [20:0] p;
    logic signed [12:0] q;
    u = $signed({1'b0, c}) - 9'sd128;
    p = u * $signed({1'b0, g});
    q = p[20:8];
    if (q > 13'sd127) begin
      q = 13'sd127;
    end else if (q < -13'sd128) begin
      q = -13'sd128;
    end
    chroma_scale = {~q[7], q[6:0]};
  endfunction

  logic        pal;
  logic [6:0]  seq;
  logic [6:0]  skip;
  logic [6:0]  acc_base;
  logic [7:0]  dec_sum;
  logic        unit;
  logic        drop;
  logic        line_end;
  logic [9:0]  nl;
  logic        fld_odd;
  logic [8:0]  win_line;
  logic [8:0]  raw_start;
  logic [9:0]  blocks;
  logic [17:0] raw_total;
  logic [8:0]  pkt;
  logic        capture;
  logic [16:0] yprod;
  logic signed [10:0] ysum;
  logic [7:0]  yclamp;
  logic [7:0]  black;
  logic [7:0]  core_thr;
  logic [7:0]  agc_eff;
  logic [16:0] gu;
  logic [16:0] gv;
  logic [15:0] burst_pct;
  logic [15:0] low_lim;
  logic [15:0] hi_lim;

  always_comb begin
    next_s = s;
    pal = s.ctrl[CTRL_PAL_BIT];
    seq = pal ? SEQ_PAL : SEQ_NTSC;
    capture = 1'b0;

    // APB: answer with pready one cycle after setup
    next_s.pready = psel_i & ~penable_i;
    next_s.pslverr = 1'b0;
    next_s.prdata = 32'h0000_0000;
    if (psel_i & ~penable_i) begin
      unique case (paddr_i)
        OFF_DECIM:    next_s.prdata = {24'h00_0000, s.decim};
        OFF_CTRL:     next_s.prdata = {24'h00_0000, s.ctrl};
        OFF_HUE:      next_s.prdata = {24'h00_0000, s.hue};
        OFF_CONTRAST: next_s.prdata = {23'h00_0000, s.contrast};
        OFF_SATU:     next_s.prdata = {23'h00_0000, s.blue_diff_gain};
        OFF_SATV:     next_s.prdata = {23'h00_0000, s.red_diff_gain};
        OFF_LUMA_OFFSET:   next_s.prdata = {24'h00_0000, s.luma_offset};
        OFF_VBI:      next_s.prdata = {16'h0000, s.vbi_cfg};
        OFF_HDELAY:   next_s.prdata = {22'h00_0000, s.hdelay};
        OFF_VWIN:     next_s.prdata = {6'h00, s.voff, 6'h00, s.vwin};
        OFF_STATUS:   next_s.prdata = {8'h00, s.agc, 6'h00, s.vbi, s.kill, s.active, s.dec_cnt};
        default:      next_s.pslverr = 1'b1;
      endcase
    end
    if (psel_i & penable_i & s.pready & pwrite_i) begin
      unique case (paddr_i)
        OFF_DECIM: begin
          next_s.decim = pwdata_i[7:0];
          // Any write with a zero count restarts the sequence, whatever the basis bits say
          if (pwdata_i[5:0] == 6'h00) begin
            next_s.dec_cnt = 6'h00;
            next_s.dec_acc = 7'h00;
            next_s.dec_run = 1'b0;
          end
        end
        OFF_CTRL:     next_s.ctrl = pwdata_i[7:0];
        OFF_HUE:      next_s.hue = pwdata_i[7:0];
        OFF_CONTRAST: next_s.contrast = pwdata_i[8:0];
        OFF_SATU:     next_s.blue_diff_gain = pwdata_i[8:0];
        OFF_SATV:     next_s.red_diff_gain = pwdata_i[8:0];
        OFF_LUMA_OFFSET:   next_s.luma_offset = pwdata_i[7:0];
        OFF_VBI:      next_s.vbi_cfg = pwdata_i[15:0];
        OFF_HDELAY:   next_s.hdelay = pwdata_i[9:0];
        OFF_VWIN: begin
          next_s.vwin = pwdata_i[9:0];
          next_s.voff = pwdata_i[VWIN_OFF_LSB +: 10];
        end
        default: ;
      endcase
    end

    // Temporal decimation: error accumulator spreads the dropped units evenly
    skip = ({1'b0, s.decim[5:0]} > seq) ? seq : {1'b0, s.decim[5:0]};
    if (s.decim[DEC_FIELD_BIT]) begin
      // Start only on a field of the parity chosen to go first, preloaded to drop it
      unit = s.dec_run | (field_odd_i == ~s.decim[DEC_PARITY_BIT]);
      acc_base = s.dec_run ? s.dec_acc : 7'(seq - skip);
    end else begin
      unit = field_odd_i;
      acc_base = s.dec_run ? s.dec_acc : 7'h00;
    end
    dec_sum = {1'b0, acc_base} + {1'b0, skip};
    drop = dec_sum >= {1'b0, seq};
    // Frame basis decides on the odd field; the even field keeps that verdict
    if (field_start_strobe_i) begin
      if (skip == 7'h00) begin
        next_s.active = 1'b1;
      end else if (unit) begin
        next_s.dec_run = 1'b1;
        next_s.active = ~drop;
        next_s.dec_acc = drop ? 7'(dec_sum - {1'b0, seq}) : dec_sum[6:0];
        next_s.dec_cnt = ({1'b0, s.dec_cnt} == 7'(seq - 7'd1)) ? 6'h00 : 6'(s.dec_cnt + 6'd1);
      end else if (s.decim[DEC_FIELD_BIT]) begin
        next_s.active = 1'b1;
      end
    end

    // Luma: contrast, brightness with clamp, then coring
    yprod = 17'(y_i * s.contrast);
    ysum = $signed({2'b00, yprod[16:8]}) + $signed({{3{s.luma_offset[7]}}, s.luma_offset});
    if (ysum < 11'sd0) begin
      yclamp = 8'h00;
    end else if (ysum > 11'sd255) begin
      yclamp = 8'hff;
    end else begin
      yclamp = ysum[7:0];
    end
    black = s.ctrl[CTRL_LIM_BIT] ? LIMITED_BLACK : 8'h00;
    unique case (s.ctrl[CTRL_CORE_LSB +: 2])
      2'd0: core_thr = 8'd0;
      2'd1: core_thr = 8'd8;
      2'd2: core_thr = 8'd16;
      2'd3: core_thr = 8'd32;
    endcase
    next_s.y = (yclamp < 8'(black + core_thr)) ? black : yclamp;

    // Chroma: saturation times automatic gain (unity 0x40)
    agc_eff = s.ctrl[CTRL_AGC_BIT] ? s.agc : AGC_UNITY;
    gu = 17'(s.blue_diff_gain * agc_eff);
    gv = 17'(s.red_diff_gain * agc_eff);
    next_s.cb = s.kill ? CHROMA_ZERO : chroma_scale(cb_i, gu[16:6]);
    next_s.cr = s.kill ? CHROMA_ZERO : chroma_scale(cr_i, gv[16:6]);
    next_s.pv = pix_valid_i & s.active;
    next_s.hue_out = pal ? 8'h00 : s.hue;

    // Per-line burst checks, taken at the strobe's trailing edge
    next_s.line_q = line_start_strobe_i;
    line_end = s.line_q & ~line_start_strobe_i;
    burst_pct = 16'(burst_amp_i * PCT_FULL);
    low_lim = 16'((pal ? LOW_PCT_PAL : LOW_PCT_NTSC) * BURST_NOMINAL);
    hi_lim = 16'((pal ? HI_PCT_PAL : HI_PCT_NTSC) * BURST_NOMINAL);
    if (line_end) begin
      // One step per line so a single noisy burst cannot swing the gain
      if (!s.ctrl[CTRL_AGC_BIT]) begin
        next_s.agc = AGC_UNITY;
      end else if (burst_amp_i < BURST_NOMINAL && s.agc < AGC_MAX) begin
        next_s.agc = s.agc + 8'd1;
      end else if (burst_amp_i > BURST_NOMINAL && s.agc > AGC_MIN) begin
        next_s.agc = s.agc - 8'd1;
      end
      // Saturating run lengths: one line on the other side of the threshold starts the run over
      if (burst_pct > low_lim) begin
        next_s.low_cnt = 7'h00;
      end else if (s.low_cnt != LOWCOL_LINES) begin
        next_s.low_cnt = 7'(s.low_cnt + 7'd1);
      end
      if (burst_pct < hi_lim) begin
        next_s.hi_cnt = 7'h00;
      end else if (s.hi_cnt != LOWCOL_LINES) begin
        next_s.hi_cnt = 7'(s.hi_cnt + 7'd1);
      end
      if (!s.kill && next_s.low_cnt == LOWCOL_LINES) begin
        next_s.kill = 1'b1;
      end else if (s.kill && next_s.hi_cnt == LOWCOL_LINES) begin
        next_s.kill = 1'b0;
      end
    end
    // Turning removal off wins over a kill decided in the same cycle
    if (!s.ctrl[CTRL_LCR_BIT]) begin
      next_s.kill = 1'b0;
    end

    // VBI capture, using the copy of the settings taken at the frame boundary
    fld_odd = s.odd;
    win_line = s.voff_a[9:1];
    // Lines count from 1, so a start that would fall at or above the top is held at line 1
    if (s.vbi_cfg_a[VBI_EXT_BIT]) begin
      blocks = pal ? BLK_PAL_EXT : BLK_NTSC_EXT;
      if (win_line > EXT_LINES) begin
        raw_start = 9'(win_line - EXT_LINES);
      end else begin
        raw_start = 9'h001;
      end
    end else begin
      blocks = pal ? BLK_PAL : BLK_NTSC;
      if (win_line == 9'h000) begin
        raw_start = 9'h001;
      end else begin
        raw_start = win_line;
      end
    end
    raw_total = {blocks, 8'h00};
    pkt = {s.vbi_cfg_a[VBI_CNT_UP_BIT], s.vbi_cfg_a[7:0]};
    nl = 10'(s.line + 10'd1);
    next_s.fifo_valid = 1'b0;

    if (field_start_strobe_i) begin
      next_s.odd = field_odd_i;
      next_s.line = 10'h000;
      next_s.vbi = VCA_VBI_IDLE;
      next_s.pk = 2'd0;
      // An odd field opens a frame; copying only there keeps one frame on one configuration
      if (field_odd_i) begin
        next_s.vbi_cfg_a = s.vbi_cfg;
        next_s.hdelay_a = s.hdelay;
        next_s.voff_a = s.voff;
      end
    end else if (line_end) begin
      next_s.line = nl;
      if (s.vbi != VCA_VBI_RAW) begin
        if (s.vbi_cfg_a[fld_odd ? VBI_CAPO_BIT : VBI_CAPE_BIT] &&
            s.vbi_cfg_a[fld_odd ? VBI_RAWO_BIT : VBI_RAWE_BIT] && nl == {1'b0, raw_start}) begin
          next_s.vbi = VCA_VBI_RAW;
          next_s.raw_dw = 18'h00000;
          next_s.pk = 2'd0;
        end else if (s.vbi_cfg_a[fld_odd ? VBI_ODD_BIT : VBI_EVEN_BIT] && pkt != 9'h000 &&
                     nl < {1'b0, win_line}) begin
          next_s.vbi = VCA_VBI_DELAY;
          next_s.samp = 11'h000;
          next_s.dw = 9'h000;
          next_s.pk = 2'd0;
        end else begin
          next_s.vbi = VCA_VBI_IDLE;
        end
      end
    end else if (vbi_sample_valid_i) begin
      // Samples landing on a line or field edge are dropped; the strobes own that cycle
      unique case (s.vbi)
        VCA_VBI_IDLE: ;
        VCA_VBI_DELAY: begin
          // Two samples per pixel, so the delay counts samples up to twice the pixel setting
          next_s.samp = 11'(s.samp + 11'd1);
          if (s.samp == {s.hdelay_a, 1'b0}) begin
            capture = 1'b1;
            next_s.vbi = VCA_VBI_LINE;
          end
        end
        VCA_VBI_LINE: capture = 1'b1;
        VCA_VBI_RAW:  capture = 1'b1;
      endcase
      if (capture) begin
        next_s.pack = {vbi_sample_i, s.pack[31:8]};
        next_s.pk = 2'(s.pk + 2'd1);
        if (s.pk == 2'd3) begin
          next_s.fifo_valid = 1'b1;
          if (s.vbi == VCA_VBI_RAW) begin
            next_s.raw_dw = 18'(s.raw_dw + 18'd1);
            if (18'(s.raw_dw + 18'd1) == raw_total) begin
              next_s.vbi = VCA_VBI_IDLE;
            end
          end else begin
            next_s.dw = 9'(s.dw + 9'd1);
            if (9'(s.dw + 9'd1) == pkt) begin
              next_s.vbi = VCA_VBI_IDLE;
            end
          end
        end
      end
    end
  end

  // Reset gives full-rate output and unity programmed gains; CTRL_RST enables the automatic gain, which starts at unity and steps with the burst
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.contrast <= GAIN_RST;
      s.blue_diff_gain <= GAIN_RST;
      s.red_diff_gain <= GAIN_RST;
      s.voff <= VOFF_RST;
      s.vwin <= VWIN_RST;
      s.voff_a <= VOFF_RST;
      s.agc <= AGC_UNITY;
      s.active <= 1'b1;
      s.y <= 8'h00;
      s.cb <= CHROMA_ZERO;
      s.cr <= CHROMA_ZERO;
      s.vbi <= VCA_VBI_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign prdata_o     = s.prdata;
  assign pready_o     = s.pready;
  assign pslverr_o    = s.pslverr;
  assign active_o     = s.active;
  assign pix_valid_o  = s.pv;
  assign y_o          = s.y;
  assign cb_o         = s.cb;
  assign cr_o         = s.cr;
  assign hue_phase_o  = s.hue_out;
  assign fifo_data_o  = s.pack;
  assign fifo_valid_o = s.fifo_valid;

endmodule

// file: tb/vca_core_properties.sv
// Port-level checker for the video capture adjust core
`timescale 1ns/1ps
module vca_core_checker (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        field_start_strobe_i,
  input wire logic        pix_valid_i,
  input wire logic        pix_valid_o,
  input wire logic        active_o,
  input wire logic        vbi_sample_valid_i,
  input wire logic        fifo_valid_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ready_after_setup_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("pready missing after setup");
  ready_needs_setup_a: assert property (!(psel_i && !penable_i) |=> !pready_o)
    else $error("pready without setup");
  error_with_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  idle_rdata_zero_a: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside access");
  pix_gated_a: assert property (pix_valid_o |-> $past(pix_valid_i) && $past(active_o))
    else $error("pixel passed while inactive");
  pix_follow_a: assert property (pix_valid_i && active_o |=> pix_valid_o)
    else $error("active pixel lost");
  // Software may clear the counter, so a register write is a legal cause too
  active_at_field_a: assert property ($changed(active_o) |-> $past(field_start_strobe_i) || $past(pwrite_i && penable_i))
    else $error("active changed mid field");
  word_spacing_a: assert property (fifo_valid_o |=> !fifo_valid_o [*3])
    else $error("words closer than four samples");
  word_cause_a: assert property (fifo_valid_o |-> $past(vbi_sample_valid_i))
    else $error("word without sample");
endmodule

bind vca_core vca_core_checker u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .field_start_strobe_i(field_start_strobe_i), .pix_valid_i(pix_valid_i),
  .pix_valid_o(pix_valid_o), .active_o(active_o), .vbi_sample_valid_i(vbi_sample_valid_i),
  .fifo_valid_o(fifo_valid_o));

// file: tb/vca_fifo_sink.sv
// Behavioural FIFO side that collects packed blank-interval words
`timescale 1ns/1ps
module vca_fifo_sink (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] fifo_data_i,
  input  wire logic        fifo_valid_i,
  output logic      [31:0] first_word_o,
  output logic      [15:0] word_cnt_o,
  output logic      [31:0] last_word_o
);
  // The stage has no back-pressure, so every pulse must be taken
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      first_word_o <= 32'h0;
      last_word_o <= 32'h0;
      word_cnt_o <= 16'h0;
    end else if (fifo_valid_i) begin
      if (word_cnt_o == 16'h0) begin
        first_word_o <= fifo_data_i;
      end
      last_word_o <= fifo_data_i;
      word_cnt_o <= word_cnt_o + 16'h1;
    end
  end
endmodule

// file: tb/video_capture_adjust_vbi_test.sv
// Self-checking bench for the video capture adjust core
`timescale 1ns/1ps
module video_capture_adjust_vbi_test;
  import vca_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic ls = 1'b0, fs = 1'b0, fodd = 1'b0, pv = 1'b0, vsv = 1'b0;
  logic [7:0] paddr = 8'h0, burst = 8'h80, y = 8'h0, cb = 8'h80, cr = 8'h80, vs = 8'h0;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata, fdata, w_first, w_last;
  wire [15:0] w_cnt;
  wire [7:0] yo, cbo, cro, hue;
  wire pready, pslverr, active, pvo, fvalid;
  int error_cnt = 0, n_compared = 0, cyc = 0;

  vca_core dut (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .line_start_strobe_i(ls), .field_start_strobe_i(fs), .field_odd_i(fodd), .burst_amp_i(burst),
    .pix_valid_i(pv), .y_i(y), .cb_i(cb), .cr_i(cr), .vbi_sample_valid_i(vsv), .vbi_sample_i(vs),
    .active_o(active), .pix_valid_o(pvo), .y_o(yo), .cb_o(cbo), .cr_o(cro), .hue_phase_o(hue),
    .fifo_data_o(fdata), .fifo_valid_o(fvalid));
  vca_fifo_sink u_sink (.sys_clk_i(clk), .rst_i(rst), .fifo_data_i(fdata), .fifo_valid_i(fvalid),
    .first_word_o(w_first), .word_cnt_o(w_cnt), .last_word_o(w_last));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop;
    end
  end

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // The request stands until the rising edge at which pready is seen high; only the bench timeout ends a wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic fld(input logic odd, output logic act);
    @(posedge clk);
    fs <= 1'b1;
    fodd <= odd;
    @(posedge clk);
    fs <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    act = active;
  endtask

  task automatic ln(input int k);
    repeat (k) begin
      @(posedge clk);
      ls <= 1'b1;
      repeat (2) @(posedge clk);
      ls <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic smp(input int k);
    for (int i = 0; i < k; i++) begin
      @(posedge clk);
      vsv <= 1'b1;
      vs <= 8'h10 + 8'(i);
    end
    @(posedge clk);
    vsv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic px(input logic [7:0] yi, ci, ri, ey, ec, er);
    @(posedge clk);
    pv <= 1'b1;
    y <= yi;
    cb <= ci;
    cr <= ri;
    @(posedge clk);
    pv <= 1'b0;
    @(negedge clk);
    chk({8'h01, ey, ec, er}, {7'h0, pvo, yo, cbo, cro});
  endtask

  task automatic t_regs;
    logic [31:0] q;
    logic e;
    apb(1'b0, OFF_CTRL, 32'h0, q, e);
    chk(32'h06, q);
    apb(1'b0, OFF_SATV, 32'h0, q, e);
    chk(32'h100, q);
    apb(1'b0, OFF_VWIN, 32'h0, q, e);
    chk(32'h001601e0, q);
    apb(1'b0, 8'h30, 32'h0, q, e);
    chk({31'h0, 1'b1}, {q[30:0], e});
  endtask

  task automatic t_hue;
    wr(OFF_CTRL, 32'h0);
    wr(OFF_HUE, 32'h40);
    repeat (2) @(negedge clk);
    chk(32'h40, 32'(hue));
    wr(OFF_CTRL, 32'h01);
    repeat (2) @(negedge clk);
    chk(32'h0, 32'(hue));
    wr(OFF_CTRL, 32'h0);
  endtask

  task automatic t_adjust;
    px(8'd100, 8'd168, 8'd60, 8'd100, 8'd168, 8'd60);
    wr(OFF_CONTRAST, 32'h080);
    wr(OFF_SATU, 32'h080);
    wr(OFF_SATV, 32'h080);
    px(8'd100, 8'd168, 8'd60, 8'd50, 8'd148, 8'd94);
    wr(OFF_CONTRAST, 32'h100);
    wr(OFF_SATU, 32'h100);
    wr(OFF_SATV, 32'h100);
    wr(OFF_LUMA_OFFSET, 32'h7f);
    px(8'd200, 8'd128, 8'd128, 8'd255, 8'd128, 8'd128);
    wr(OFF_LUMA_OFFSET, 32'h80);
    px(8'd50, 8'd128, 8'd128, 8'd0, 8'd128, 8'd128);
    wr(OFF_LUMA_OFFSET, 32'h0);
    wr(OFF_CTRL, 32'h10);
    px(8'd5, 8'd128, 8'd128, 8'd0, 8'd128, 8'd128);
    px(8'd10, 8'd128, 8'd128, 8'd10, 8'd128, 8'd128);
    wr(OFF_CTRL, 32'h18);
    px(8'd20, 8'd128, 8'd128, 8'd16, 8'd128, 8'd128);
  endtask

  task automatic t_lowcol;
    wr(OFF_CTRL, 32'h04);
    burst <= 8'h00;
    ln(128);
    px(8'd100, 8'd200, 8'd60, 8'd100, 8'h80, 8'h80);
    burst <= 8'h80;
    ln(128);
    px(8'd100, 8'd200, 8'd60, 8'd100, 8'd200, 8'd60);
    wr(OFF_CTRL, 32'h02);
    burst <= 8'h40;
    ln(70);
    px(8'd100, 8'd168, 8'd60, 8'd100, 8'd208, 8'd0);
    burst <= 8'h80;
    wr(OFF_CTRL, 32'h0);
    px(8'd100, 8'd168, 8'd60, 8'd100, 8'd168, 8'd60);
  endtask

  task automatic t_reset;
    logic [31:0] q;
    logic e, a;
    fld(1'b1, a);
    apb(1'b0, OFF_STATUS, 32'h0, q, e);
    chk(32'h41, 32'(q[7:0]));
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, OFF_STATUS, 32'h0, q, e);
    chk(32'h00400040, q);
    apb(1'b0, OFF_DECIM, 32'h0, q, e);
    chk(32'h0, q);
  endtask

  task automatic t_raw;
    logic a;
    wr(OFF_VBI, 32'ha000);
    fld(1'b1, a);
    ln(10);
    smp(4);
    chk(32'd4, 32'(w_cnt));
    ln(1);
    smp(8);
    chk(32'd6, 32'(w_cnt));
    ln(1);
    smp(4);
    chk(32'd7, 32'(w_cnt));
    wr(OFF_VWIN, 32'h000201e0);
    wr(OFF_VBI, 32'ha800);
    fld(1'b1, a);
    ln(1);
    smp(4);
    chk(32'd8, 32'(w_cnt));
  endtask

  task automatic t_frames;
    logic a, b;
    wr(OFF_DECIM, 32'h0);
    wr(OFF_DECIM, 32'h02);
    for (int f = 1; f <= 60; f++) begin
      fld(1'b1, a);
      chk(32'((f % 30) != 0), 32'(a));
      fld(1'b0, b);
      chk(32'(a), 32'(b));
    end
  endtask

  task automatic t_fields(input logic [7:0] setv, input logic par);
    logic a, prev, seen;
    int drops;
    wr(OFF_DECIM, 32'h0);
    wr(OFF_DECIM, 32'(setv));
    drops = 0;
    seen = 1'b0;
    prev = 1'b1;
    for (int f = 0; f < 60; f++) begin
      fld(f[0] == 1'b0, a);
      if (a === 1'b0) begin
        drops++;
        if (!seen) chk(32'(par), 32'(f[0]));
        seen = 1'b1;
      end
      chk(32'h1, 32'(a | prev));
      prev = a;
    end
    chk(32'd30, 32'(drops));
    wr(OFF_DECIM, 32'h0);
    repeat (4) begin
      fld(1'b1, a);
      chk(32'h1, 32'(a));
    end
  endtask

  task automatic t_vbi;
    logic a;
    wr(OFF_HDELAY, 32'h1);
    wr(OFF_VBI, 32'h0402);
    fld(1'b1, a);
    ln(1);
    smp(12);
    chk(32'd2, 32'(w_cnt));
    chk(32'h15141312, w_first);
    chk(32'h19181716, w_last);
    // Even enable written mid frame must wait for the next frame
    wr(OFF_VBI, 32'h0602);
    fld(1'b0, a);
    ln(1);
    smp(12);
    chk(32'd2, 32'(w_cnt));
    fld(1'b1, a);
    fld(1'b0, a);
    ln(1);
    smp(12);
    chk(32'd4, 32'(w_cnt));
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_hue;
    t_adjust;
    t_lowcol;
    t_frames;
    t_reset;
    t_fields(8'h9e, 1'b0);
    t_fields(8'hde, 1'b1);
    t_vbi;
    t_raw;
    report_and_stop;
  end
endmodule
